//--- src/pacr_regs.sv
// Register bank for the port 2 negotiation registers and port 1 cable test
// and special control registers, with an APB slave and one interrupt.
// Assumes phy_in comes from another clock domain and holds results stable
// while test_done is high.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module pacr_regs #(
   parameter logic [15:0] ID_UPPER = 16'h5A5A // Arbitrary identification value
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pacr_pkg::ADDR_W-1:0] paddr,
   input wire logic [pacr_pkg::DATA_W-1:0] pwdata,
   output logic [pacr_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pacr_pkg::pacr_phy_in_s phy_in,
   output pacr_pkg::pacr_phy_ctl_s phy_ctl,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations
   pacr_pkg::pacr_phy_in_s sync1_ff;
   pacr_pkg::pacr_phy_in_s sync2_ff;
   logic done_prev_ff;
   logic pol_prev_ff;
   logic [4:0] partner_prev_ff;
   pacr_pkg::pacr_ct_state_e state_ff;
   logic start_pulse_ff;
   logic [1:0] result_ff;
   logic short_ff;
   logic [8:0] count_ff;
   logic adv_pause_ff;
   logic [3:0] adv_caps_ff;
   logic force_ff;
   logic psave_off_ff;
   logic loop_ff;
   logic [pacr_pkg::EV_W-1:0] irq_stat_ff;
   logic [pacr_pkg::EV_W-1:0] irq_en_ff;
   logic irq_ff;
   logic [pacr_pkg::DATA_W-1:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [pacr_pkg::DATA_W-1:0] nxt_prdata;
   logic nxt_pslverr;
   logic [15:0] rd16;
   logic [pacr_pkg::IDX_W-1:0] idx;
   logic mapped;
   logic wr_en;
   logic setup;
   logic done_rise;
   logic start_req;
   logic [pacr_pkg::EV_W-1:0] events;

   ////////////////////////////////////////////////////////////////////////////////
   // Two-flop synchroniser for every PHY status input
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end
      else
      begin
         sync1_ff <= phy_in;
         sync2_ff <= sync1_ff;
      end
   end

   // History of synchronised levels for edge and change detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         done_prev_ff <= 1'b0;
         pol_prev_ff <= 1'b0;
         partner_prev_ff <= '0;
      end
      else
      begin
         done_prev_ff <= sync2_ff.test_done;
         pol_prev_ff <= sync2_ff.pol_reversed;
         partner_prev_ff <= {sync2_ff.partner_pause, sync2_ff.partner_caps};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB decode: no wait states, answer registered in the setup cycle
   assign idx = paddr[pacr_pkg::ADDR_W-1:2];
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready_ff && pwrite;
   assign done_rise = sync2_ff.test_done && !done_prev_ff;
   assign start_req = wr_en && !pslverr_ff && (state_ff == pacr_pkg::ST_IDLE)
      && (((idx == pacr_pkg::IDX_CABLE) && pwdata[pacr_pkg::CT_START_BIT])
      || ((idx == pacr_pkg::IDX_MIRROR) && pwdata[pacr_pkg::MR_START_BIT]));

   // Read multiplexer; reserved fields read their defaults
   always_comb
   begin
      rd16 = '0;
      mapped = 1'b1;
      unique case (idx)
         pacr_pkg::IDX_CABLE:
         begin
            rd16[pacr_pkg::CT_START_BIT] = (state_ff == pacr_pkg::ST_RUN);
            rd16[pacr_pkg::CT_RES_HI:pacr_pkg::CT_RES_LO] = result_ff;
            rd16[pacr_pkg::CT_SHORT_BIT] = short_ff;
            rd16[pacr_pkg::CT_CNT_HI:0] = count_ff;
         end
         pacr_pkg::IDX_SPECIAL:
         begin
            rd16[pacr_pkg::SP_POL_BIT] = sync2_ff.pol_reversed;
            rd16[pacr_pkg::SP_FORCE_BIT] = force_ff;
            rd16[pacr_pkg::SP_PSAVE_BIT] = psave_off_ff;
            rd16[pacr_pkg::SP_LOOP_BIT] = loop_ff;
         end
         pacr_pkg::IDX_ID_UPPER:
            rd16 = ID_UPPER;
         pacr_pkg::IDX_ADVERTISE:
         begin
            rd16[pacr_pkg::ADV_PAUSE_BIT] = adv_pause_ff;
            rd16[pacr_pkg::CAPS_HI:pacr_pkg::CAPS_LO] = adv_caps_ff;
            rd16[pacr_pkg::SEL_HI:0] = pacr_pkg::SELECTOR_VAL;
         end
         pacr_pkg::IDX_PARTNER:
         begin
            rd16[pacr_pkg::ADV_PAUSE_BIT] = sync2_ff.partner_pause;
            rd16[pacr_pkg::CAPS_HI:pacr_pkg::CAPS_LO] = sync2_ff.partner_caps;
            rd16[pacr_pkg::SEL_HI:0] = pacr_pkg::SELECTOR_VAL;
         end
         pacr_pkg::IDX_MIRROR:
         begin
            rd16[pacr_pkg::MR_SHORT_BIT] = short_ff;
            rd16[pacr_pkg::MR_RES_HI:pacr_pkg::MR_RES_LO] = result_ff;
            rd16[pacr_pkg::MR_START_BIT] = (state_ff == pacr_pkg::ST_RUN);
            rd16[pacr_pkg::MR_FORCE_BIT] = force_ff;
            rd16[pacr_pkg::MR_PSAVE_BIT] = psave_off_ff;
            rd16[pacr_pkg::MR_LOOP_BIT] = loop_ff;
            rd16[pacr_pkg::CT_CNT_HI:0] = count_ff;
         end
         pacr_pkg::IDX_IRQ_STATUS:
            rd16[pacr_pkg::EV_W-1:0] = irq_stat_ff;
         pacr_pkg::IDX_IRQ_CLEAR:
            rd16 = '0;
         pacr_pkg::IDX_IRQ_ENABLE:
            rd16[pacr_pkg::EV_W-1:0] = irq_en_ff;
         default:
            mapped = 1'b0;
      endcase
      nxt_prdata = {16'h0000, rd16};
      nxt_pslverr = !mapped || (paddr[1:0] != 2'h0);
   end

   // Bus answer flops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_ff <= '0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pready_ff <= setup;
         if (setup)
         begin
            prdata_ff <= pwrite ? '0 : nxt_prdata;
            pslverr_ff <= nxt_pslverr;
         end
         else
         begin
            pslverr_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Cable test sequencer: start on write, self-clear on completion
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= pacr_pkg::ST_IDLE;
         start_pulse_ff <= 1'b0;
         result_ff <= pacr_pkg::CT_NORMAL;
         short_ff <= 1'b0;
         count_ff <= '0;
      end
      else
      begin
         start_pulse_ff <= start_req;
         unique case (state_ff)
            pacr_pkg::ST_IDLE:
               if (start_req)
                  state_ff <= pacr_pkg::ST_RUN;
            pacr_pkg::ST_RUN:
               if (done_rise)
               begin
                  state_ff <= pacr_pkg::ST_IDLE;
                  result_ff <= sync2_ff.test_result;
                  short_ff <= sync2_ff.near_short_flag;
                  count_ff <= sync2_ff.fault_count;
               end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Writable control fields; the special controls are also reached from the mirror location
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         adv_pause_ff <= pacr_pkg::ADV_PAUSE_RST;
         adv_caps_ff <= pacr_pkg::ADV_CAPS_RST;
         force_ff <= pacr_pkg::FORCE_RST;
         psave_off_ff <= pacr_pkg::PSAVE_OFF_RST;
         loop_ff <= pacr_pkg::LOOP_RST;
      end
      else if (wr_en && !pslverr_ff)
      begin
         if (idx == pacr_pkg::IDX_ADVERTISE)
         begin
            adv_pause_ff <= pwdata[pacr_pkg::ADV_PAUSE_BIT];
            adv_caps_ff <= pwdata[pacr_pkg::CAPS_HI:pacr_pkg::CAPS_LO];
         end
         if (idx == pacr_pkg::IDX_SPECIAL)
         begin
            force_ff <= pwdata[pacr_pkg::SP_FORCE_BIT];
            psave_off_ff <= pwdata[pacr_pkg::SP_PSAVE_BIT];
            loop_ff <= pwdata[pacr_pkg::SP_LOOP_BIT];
         end
         if (idx == pacr_pkg::IDX_MIRROR)
         begin
            force_ff <= pwdata[pacr_pkg::MR_FORCE_BIT];
            psave_off_ff <= pwdata[pacr_pkg::MR_PSAVE_BIT];
            loop_ff <= pwdata[pacr_pkg::MR_LOOP_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt: sticky status, write-one-to-clear, enable; set wins over clear
   assign events[pacr_pkg::EV_DONE] = done_rise && (state_ff == pacr_pkg::ST_RUN);
   assign events[pacr_pkg::EV_POL] = sync2_ff.pol_reversed != pol_prev_ff;
   assign events[pacr_pkg::EV_PARTNER] =
      {sync2_ff.partner_pause, sync2_ff.partner_caps} != partner_prev_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_ff <= '0;
         irq_en_ff <= '0;
         irq_ff <= 1'b0;
      end
      else
      begin
         if (wr_en && !pslverr_ff && (idx == pacr_pkg::IDX_IRQ_CLEAR))
            irq_stat_ff <= (irq_stat_ff & ~pwdata[pacr_pkg::EV_W-1:0]) | events;
         else
            irq_stat_ff <= irq_stat_ff | events;
         if (wr_en && !pslverr_ff && (idx == pacr_pkg::IDX_IRQ_ENABLE))
            irq_en_ff <= pwdata[pacr_pkg::EV_W-1:0];
         irq_ff <= |(irq_stat_ff & irq_en_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs, each straight from a flop
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign irq = irq_ff;
   assign phy_ctl.test_start = start_pulse_ff;
   assign phy_ctl.adv_pause = adv_pause_ff;
   assign phy_ctl.adv_caps = adv_caps_ff;
   assign phy_ctl.force_link = force_ff;
   assign phy_ctl.psave_off = psave_off_ff;
   assign phy_ctl.near_loopback = loop_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions and covers
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Upper identifier always reads its fixed value
   id_upper_read_a: assert property (
      setup && !pwrite && idx == pacr_pkg::IDX_ID_UPPER
      |=> prdata[15:0] == ID_UPPER)
      else $error("upper id read wrong");

   // Advertisement write reaches the control outputs
   adv_write_a: assert property (
      wr_en && !pslverr_ff && idx == pacr_pkg::IDX_ADVERTISE
      |=> phy_ctl.adv_pause == $past(pwdata[pacr_pkg::ADV_PAUSE_BIT])
      && phy_ctl.adv_caps == $past(pwdata[pacr_pkg::CAPS_HI:pacr_pkg::CAPS_LO]))
      else $error("advertise write lost");

   // Advertisement read shows stored speeds and fixed selector
   adv_read_a: assert property (
      setup && !pwrite && idx == pacr_pkg::IDX_ADVERTISE
      |=> prdata[pacr_pkg::CAPS_HI:pacr_pkg::CAPS_LO] == $past(adv_caps_ff)
      && prdata[pacr_pkg::SEL_HI:0] == pacr_pkg::SELECTOR_VAL)
      else $error("advertise read wrong");

   // Partner ability read follows the synchronised pause input and shows the fixed selector
   partner_read_a: assert property (
      setup && !pwrite && idx == pacr_pkg::IDX_PARTNER
      |=> prdata[pacr_pkg::ADV_PAUSE_BIT] == $past(sync2_ff.partner_pause)
      && prdata[pacr_pkg::SEL_HI:0] == pacr_pkg::SELECTOR_VAL)
      else $error("partner read wrong");

   // Start request gives one launch pulse and the busy state
   test_start_a: assert property (
      start_req
      |=> start_pulse_ff && state_ff == pacr_pkg::ST_RUN ##1 !start_pulse_ff)
      else $error("start not launched");

   // Start bit reads high while a test runs
   busy_read_a: assert property (
      setup && !pwrite && idx == pacr_pkg::IDX_CABLE && state_ff == pacr_pkg::ST_RUN
      |=> prdata[pacr_pkg::CT_START_BIT])
      else $error("start bit read low while running");

   // Result code captured at completion
   result_code_a: assert property (
      state_ff == pacr_pkg::ST_RUN && done_rise
      |=> result_ff == $past(sync2_ff.test_result))
      else $error("result code wrong");

   // Completion returns to idle with short flag and count captured
   test_finish_a: assert property (
      state_ff == pacr_pkg::ST_RUN && done_rise
      |=> state_ff == pacr_pkg::ST_IDLE && count_ff == $past(sync2_ff.fault_count)
      && short_ff == $past(sync2_ff.near_short_flag))
      else $error("finish wrong");

   // Results stay put while no test runs
   result_hold_a: assert property (
      state_ff == pacr_pkg::ST_IDLE
      |=> $stable(result_ff) && $stable(count_ff))
      else $error("result changed idle");

   // Polarity bit follows the synchronised input
   pol_read_a: assert property (
      setup && !pwrite && idx == pacr_pkg::IDX_SPECIAL
      |=> prdata[pacr_pkg::SP_POL_BIT] == $past(sync2_ff.pol_reversed))
      else $error("polarity read wrong");

   // Special register write reaches the control outputs
   special_write_a: assert property (
      wr_en && !pslverr_ff && idx == pacr_pkg::IDX_SPECIAL
      |=> phy_ctl.force_link == $past(pwdata[pacr_pkg::SP_FORCE_BIT])
      && phy_ctl.psave_off == $past(pwdata[pacr_pkg::SP_PSAVE_BIT])
      && phy_ctl.near_loopback == $past(pwdata[pacr_pkg::SP_LOOP_BIT]))
      else $error("special write lost");

   // Mirror write lands in the shared storage
   mirror_write_a: assert property (
      wr_en && !pslverr_ff && idx == pacr_pkg::IDX_MIRROR
      |=> phy_ctl.force_link == $past(pwdata[pacr_pkg::MR_FORCE_BIT])
      && phy_ctl.psave_off == $past(pwdata[pacr_pkg::MR_PSAVE_BIT])
      && phy_ctl.near_loopback == $past(pwdata[pacr_pkg::MR_LOOP_BIT]))
      else $error("mirror write lost");

   // Unmapped or misaligned access answers with an error
   bad_access_a: assert property (
      setup && nxt_pslverr
      |=> pready && pslverr)
      else $error("bad access not flagged");

   // Every event lands in the status, even against a clear
   irq_level_a: assert property (
      events != '0
      |=> (irq_stat_ff & $past(events)) == $past(events))
      else $error("event not latched");

   // Interrupt output follows enabled status one cycle later
   irq_out_a: assert property (
      1'b1
      |=> irq == $past(|(irq_stat_ff & irq_en_ff)))
      else $error("interrupt level wrong");

   test_done_c: cover property (state_ff == pacr_pkg::ST_RUN && done_rise);
   mirror_wr_c: cover property (wr_en && idx == pacr_pkg::IDX_MIRROR);
   irq_raise_c: cover property (!irq_ff ##1 irq_ff);
   bad_addr_c: cover property (pslverr_ff);
   pol_event_c: cover property (events[pacr_pkg::EV_POL]);

endmodule

//--- src/pacr_pkg.sv
// Constants, types and field layout of the port PHY management register bank.
// Assumes an APB master with 32-bit data; registers sit at byte address 4 * index.
package pacr_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus geometry and register indices
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int IDX_W = 6;
   localparam logic [IDX_W-1:0] IDX_CABLE = 6'h00;
   localparam logic [IDX_W-1:0] IDX_SPECIAL = 6'h02;
   localparam logic [IDX_W-1:0] IDX_ID_UPPER = 6'h06;
   localparam logic [IDX_W-1:0] IDX_ADVERTISE = 6'h08;
   localparam logic [IDX_W-1:0] IDX_PARTNER = 6'h0A;
   localparam logic [IDX_W-1:0] IDX_MIRROR = 6'h10;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h11;
   localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 6'h12;
   localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 6'h13;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int ADV_PAUSE_BIT = 10;
   localparam int CAPS_HI = 8;
   localparam int CAPS_LO = 5;
   localparam int SEL_HI = 4;
   localparam logic [4:0] SELECTOR_VAL = 5'h01;
   localparam int CT_START_BIT = 15;
   localparam int CT_RES_HI = 14;
   localparam int CT_RES_LO = 13;
   localparam int CT_SHORT_BIT = 12;
   localparam int CT_CNT_HI = 8;
   localparam int SP_POL_BIT = 5;
   localparam int SP_FORCE_BIT = 3;
   localparam int SP_PSAVE_BIT = 2;
   localparam int SP_LOOP_BIT = 1;
   localparam int MR_SHORT_BIT = 15;
   localparam int MR_RES_HI = 14;
   localparam int MR_RES_LO = 13;
   localparam int MR_START_BIT = 12;
   localparam int MR_FORCE_BIT = 11;
   localparam int MR_PSAVE_BIT = 10;
   localparam int MR_LOOP_BIT = 9;
   localparam int EV_DONE = 0;
   localparam int EV_POL = 1;
   localparam int EV_PARTNER = 2;
   localparam int EV_W = 3;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic ADV_PAUSE_RST = 1'b1;
   localparam logic [3:0] ADV_CAPS_RST = 4'hF;
   localparam logic FORCE_RST = 1'b0;
   localparam logic PSAVE_OFF_RST = 1'b1;
   localparam logic LOOP_RST = 1'b0;

   ////////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {
      CT_NORMAL = 2'h0,
      CT_OPEN = 2'h1,
      CT_SHORTED = 2'h2,
      CT_FAILED = 2'h3
   } pacr_result_e;

   typedef enum logic {ST_IDLE, ST_RUN} pacr_ct_state_e;

   // Status coming from the PHY analog and negotiation logic
   typedef struct packed {
      logic test_done;
      logic [1:0] test_result;
      logic near_short_flag;
      logic [8:0] fault_count;
      logic pol_reversed;
      logic partner_pause;
      logic [3:0] partner_caps;
   } pacr_phy_in_s;

   // Controls driven into the PHY
   typedef struct packed {
      logic test_start;
      logic adv_pause;
      logic [3:0] adv_caps;
      logic force_link;
      logic psave_off;
      logic near_loopback;
   } pacr_phy_ctl_s;

endpackage

//--- testbench/pacr_regs_tb.sv
// Self-checking bench for the PHY management register bank, APB driven.
// Assumes pacr_pkg and pacr_regs are compiled first; design holds its own assertions.
`timescale 1ns/1ps
module pacr_regs_tb;
   ////////////////////////////////////////////////////////////////////////////////
   // Signals and bench state
   typedef struct packed {logic [31:0] data; logic err;} pacr_note_s;
   localparam logic [15:0] ID_VAL = 16'hC3A5; // Arbitrary identification value
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [pacr_pkg::ADDR_W-1:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   pacr_pkg::pacr_phy_in_s phy_in = '0;
   pacr_pkg::pacr_phy_ctl_s phy_ctl;
   pacr_note_s notes[$];
   pacr_note_s cur;
   int num_errors = 0;
   int check_count = 0;
   logic [31:0] rnd_state = 32'h7F69;
   logic [31:0] v;
   logic [31:0] last = 32'h0;

   // Clock at 40 MHz
   always #12.5 pclk = ~pclk;

   pacr_regs #(.ID_UPPER(ID_VAL)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .phy_in(phy_in), .phy_ctl(phy_ctl), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] rnd();
      rnd_state = {rnd_state[30:0], rnd_state[31] ^ rnd_state[21] ^ rnd_state[1] ^ rnd_state[0]};
      return rnd_state;
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         $display("mismatch %s expected %h seen %h", name, exp, seen);
         num_errors++;
      end
   endtask

   task automatic complete_run();
      if (num_errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // One APB transfer; the expected answer is queued for the monitor
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic err);
      int n;
      n = 0;
      notes.push_back('{e, err});
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      check("pready", {31'h0, pready}, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, e, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Monitor: compares each completed transfer against the oldest note
   always @(posedge pclk)
   begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
      begin
         if (notes.size() == 0)
            check("note queue", 32'h0, 32'h1);
         else
         begin
            cur = notes.pop_front();
            if (!cur.err)
               check("prdata", prdata, cur.data);
            check("pslverr", {31'h0, pslverr}, {31'h0, cur.err});
         end
      end
   end

   // Watchdog against a hung handshake
   initial
   begin
      #(25 * 20000);
      $display("mismatch watchdog expected finish seen timeout");
      num_errors++;
      complete_run();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      #1 check("ctl reset", {23'h0, phy_ctl}, {23'h0, 9'h0FA});
      rd(8'h00, 32'h0);
      rd(8'h08, 32'h4);
      rd(8'h18, {16'h0, ID_VAL});
      rd(8'h20, 32'h05E1);
      rd(8'h28, 32'h1);
      rd(8'h40, 32'h0400);
      rd(8'h44, 32'h0);
      rd(8'h4C, 32'h0);
      apb(1'b0, 8'h3C, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 8'h21, 32'h0, 32'h0, 1'b1);
      rd(8'h20, 32'h05E1);
      // Random register traffic
      for (int i = 0; i < 6; i++)
      begin
         v = rnd();
         wr(8'h20, v);
         rd(8'h20, (v & 32'h05E0) | 32'h1);
         check("adv ctl", {27'h0, phy_ctl.adv_pause, phy_ctl.adv_caps}, {27'h0, v[10], v[8:5]});
         wr(8'h18, v);
         rd(8'h18, {16'h0, ID_VAL});
         phy_in.partner_pause <= v[10];
         phy_in.partner_caps <= v[8:5];
         wr(8'h28, 32'hFFFF);
         rd(8'h28, {21'h0, v[10], 1'b0, v[8:5], 5'h01});
         v = rnd();
         wr(8'h08, v);
         rd(8'h08, v & 32'hE);
         check("spc ctl", {29'h0, phy_ctl.force_link, phy_ctl.psave_off, phy_ctl.near_loopback}, {29'h0, v[3:1]});
         rd(8'h40, {20'h0, v[3:1], 9'h0});
         wr(8'h40, {20'h0, ~v[3:1], 9'h0});
         rd(8'h08, {28'h0, ~v[3:1], 1'b0});
      end
      wr(8'h48, 32'h7);
      rd(8'h44, 32'h0);
      wr(8'h08, 32'h4);
      // Polarity event, masked then enabled interrupt
      phy_in.pol_reversed <= 1'b1;
      repeat (4) @(posedge pclk);
      rd(8'h08, 32'h24);
      rd(8'h44, 32'h2);
      check("irq masked", {31'h0, irq}, 32'h0);
      wr(8'h4C, 32'h2);
      repeat (2) @(posedge pclk);
      check("irq set", {31'h0, irq}, 32'h1);
      wr(8'h48, 32'h2);
      repeat (2) @(posedge pclk);
      check("irq clear", {31'h0, irq}, 32'h0);
      phy_in.pol_reversed <= 1'b0;
      repeat (4) @(posedge pclk);
      rd(8'h08, 32'h4);
      wr(8'h48, 32'h7);
      wr(8'h4C, 32'h1);
      // Cable test through every result code; last one launched via mirror
      for (int r = 0; r < 4; r++)
      begin
         v = rnd();
         wr(r == 3 ? 8'h40 : 8'h00, r == 3 ? 32'h1400 : 32'h8000);
         #1 check("test start", {31'h0, phy_ctl.test_start}, 32'h1);
         rd(8'h00, 32'h8000 | last);
         wr(8'h00, 32'h8000);
         #1 check("start busy", {31'h0, phy_ctl.test_start}, 32'h0);
         phy_in.test_result <= r[1:0];
         phy_in.near_short_flag <= v[12];
         phy_in.fault_count <= v[8:0];
         @(posedge pclk);
         phy_in.test_done <= 1'b1;
         repeat (7) @(posedge pclk);
         last = {17'h0, r[1:0], v[12], 3'h0, v[8:0]};
         check("irq done", {31'h0, irq}, 32'h1);
         rd(8'h00, last);
         rd(8'h40, {16'h0, v[12], r[1:0], 4'b0010, v[8:0]});
         wr(8'h48, 32'h1);
         phy_in.test_done <= 1'b0;
         repeat (3) @(posedge pclk);
         check("irq idle", {31'h0, irq}, 32'h0);
      end
      // Second reset after the last test has finished restores defaults
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h00, 32'h0);
      rd(8'h20, 32'h05E1);
      repeat (2) @(posedge pclk);
      complete_run();
   end
endmodule
